/* File: pkg/dfp_defs.vh */
// Constants for the drive front panel: register map, fields, timing.
`ifndef DFP_DEFS_VH
`define DFP_DEFS_VH
// ==========================================================================
// Register byte offsets
`define DFP_CTRL_OFF 12'h000
`define DFP_STATUS_OFF 12'h004
`define DFP_KEY_OFF 12'h008
`define DFP_PARAM_OFF 12'h00C
`define DFP_DISP_OFF 12'h010
`define DFP_LED_OFF 12'h014
// ==========================================================================
// Control register fields and reset value
`define DFP_CTRL_RST 32'h00000000
`define DFP_CTRL_DIR_BIT 0
`define DFP_CTRL_LOCK_BIT 1
`define DFP_CTRL_SRC_LSB 4
`define DFP_CTRL_SRC_MSB 5
`define DFP_SRC_KEYPAD 2'h2
// ==========================================================================
// Key register bits
`define DFP_KEY_FUNC 0
`define DFP_KEY_UP 1
`define DFP_KEY_DOWN 2
`define DFP_KEY_STORE 3
`define DFP_KEY_RUN 4
`define DFP_KEY_STOP 5
// ==========================================================================
// Monitor item codes
`define DFP_ITEM_FREQ 4'h1
`define DFP_ITEM_CURR 4'h2
`define DFP_ITEM_IN 4'h5
`define DFP_ITEM_OUT 4'h6
`define DFP_ITEM_SCALED 4'h7
`define DFP_ITEM_POWER 4'hE
`define DFP_ITEM_VOLT 4'hD
// ==========================================================================
// Limits and timing
`define DFP_FREQ_MAX 16'h0FA0
`define DFP_CLK_HZ 25000000
`define DFP_FILT_MS 100
`define DFP_FILT_SHIFT 4
// One filter step per sixteenth of the time constant: 156250 cycles.
`define DFP_FILT_STEP_CYC 20'h2625A
`define DFP_TICK_CYC 25000
`endif

/* File: design/dfp_seg_fmt.v */
// Seven-segment digit formatter with decimal-point placement.
`timescale 1ns/1ps
`include "dfp_defs.vh"
module dfp_seg_fmt (
  // Value in
  input wire [15:0] value_i,
  input wire scaled_i,
  input wire [7:0] raw_seg_i,
  input wire raw_i,
  // Digits out, digit 3 leftmost
  output reg [31:0] seg_o
);
  // ========================================================================
  // Helpers.
  function [6:0] dfp_seg7;
    input [3:0] d;
    begin
      case (d)
        4'h0: dfp_seg7 = 7'h3F;
        4'h1: dfp_seg7 = 7'h06;
        4'h2: dfp_seg7 = 7'h5B;
        4'h3: dfp_seg7 = 7'h4F;
        4'h4: dfp_seg7 = 7'h66;
        4'h5: dfp_seg7 = 7'h6D;
        4'h6: dfp_seg7 = 7'h7D;
        4'h7: dfp_seg7 = 7'h07;
        4'h8: dfp_seg7 = 7'h7F;
        4'h9: dfp_seg7 = 7'h6F;
        default: dfp_seg7 = 7'h00;
      endcase
    end
  endfunction

  function [3:0] dfp_dig;
    input [15:0] v;
    input [15:0] div;
    reg [15:0] r;
    begin
      r = (v / div) % 16'h000A;
      dfp_dig = r[3:0];
    end
  endfunction

  reg [15:0] shown;
  reg [3:0] dp;
  // Scaled values are hundredths; sixteen bits stop at 655.35, so the
  // trailing-point and no-point ranges can never be reached here.
  // Unscaled values are tenths, like the output frequency.
  // decimal point placement
  always @* begin
    shown = value_i;
    dp = 4'h2;
    if (scaled_i && value_i <= 16'h270F) begin
      dp = 4'h4;
    end else if (scaled_i) begin
      shown = value_i / 16'h000A;
    end
  end

  always @* begin
    if (raw_i) begin
      seg_o = {8'h00, 8'h00, 8'h00, raw_seg_i};
    end else begin
      seg_o[31:24] = {dp[3], dfp_seg7(dfp_dig(shown, 16'h03E8))};
      seg_o[23:16] = {dp[2], dfp_seg7(dfp_dig(shown, 16'h0064))};
      seg_o[15:8] = {dp[1], dfp_seg7(dfp_dig(shown, 16'h000A))};
      seg_o[7:0] = {dp[0], dfp_seg7(dfp_dig(shown, 16'h0001))};
    end
  end
endmodule // dfp_seg_fmt

/* File: design/dfp_panel.v */
// Drive front panel mode controller with APB register access.
// How it works
// - Run lamp lit while output enabled, dark when stopped.
// - Program lamp in edit mode, and whenever frequency monitor shows.
// - Source keypad lets up/down change target on frequency monitor.
// - Run key starts only when run-enable lit; direction from routing bit.
// - Run-enable lamp lit exactly when run key would be honoured.
// - Stop key while running ramps down at deceleration rate.
// - Stop key while tripped clears the alarm.
// - Values and codes shown on four seven-segment digits.
// - Unit lamps follow monitored item; power lights volts and amps.
// - Alarm lamp on while tripped, off once cleared.
// - Up/down step item selection or edited value.
// - Store key in program mode commits edited value to memory.
// - Last stored item becomes display default after power-up.
// - Run/stop and program/monitor are independent toggles.
// - Fault enters trip, leaves run, switches output off.
// - Run requests ignored while tripped.
// - Run-mode edits checked against low or high access level.
// - Monitor items viewable in run and stop; function key shows value.
// - Terminal status items drive one segment per terminal.
// - Output current low-pass filtered, 100 ms time constant.
// - Scaled frequency decimal point placed by magnitude.
// - Output frequency shown live from 0 to 400.0 Hz.
`timescale 1ns/1ps
`include "dfp_defs.vh"
module dfp_panel (
  // Clock and reset
  input wire clk_sys_i,
  input wire rst_i,
  // APB slave
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [11:0] paddr_i,
  input wire [31:0] pwdata_i,
  output wire [31:0] prdata_o,
  output wire pready_o,
  output wire pslverr_o,
  // Keypad, one-cycle press pulses
  input wire key_func_i,
  input wire key_up_i,
  input wire key_down_i,
  input wire key_store_i,
  input wire key_run_i,
  input wire key_stop_i,
  // Drive core
  input wire fault_i,
  input wire stopped_i,
  input wire [15:0] out_freq_i,
  input wire [15:0] out_curr_i,
  input wire [15:0] scaled_freq_i,
  input wire [7:0] in_term_i,
  input wire [7:0] out_term_i,
  input wire [15:0] nvm_default_i,
  input wire edit_low_ok_i,
  input wire edit_high_ok_i,
  output reg out_enable_o,
  output reg run_fwd_o,
  output reg run_rev_o,
  output reg decel_stop_o,
  output reg [15:0] target_freq_o,
  output reg nvm_write_o,
  output reg [15:0] nvm_addr_o,
  output reg [15:0] nvm_data_o,
  // Indicators
  output reg run_led_o,
  output reg program_indicator_o,
  output reg run_enable_led_o,
  output reg alarm_led_o,
  output reg hz_led_o,
  output reg volt_led_o,
  output reg amp_led_o,
  output reg [31:0] seg_o
);
  // ========================================================================
  // Mode state.
  localparam ST_STOP = 2'h0;
  localparam ST_RUN = 2'h1;
  localparam ST_TRIP = 2'h2;

  reg [1:0] state_reg;
  reg [1:0] state_next;
  reg program_mode_flag_reg;
  reg show_value_reg;
  reg [15:0] item_reg;
  reg [15:0] edit_val_reg;
  reg edited_reg;
  reg [31:0] ctrl_reg;
  reg [7:0] key_reg;
  reg [15:0] filt_curr_reg;
  reg [19:0] filt_cnt_reg;
  reg default_loaded_reg;
  reg [31:0] rdata;
  reg [15:0] disp_val;
  reg [7:0] raw_seg;
  reg raw_sel;
  wire [31:0] fmt_seg;
  wire [19:0] filt_step_cyc;

  wire apb_wr = psel_i & penable_i & pwrite_i;
  wire apb_key = apb_wr & (paddr_i == `DFP_KEY_OFF);
  wire k_func = key_func_i | (apb_key & pwdata_i[`DFP_KEY_FUNC]);
  wire k_up = key_up_i | (apb_key & pwdata_i[`DFP_KEY_UP]);
  wire k_down = key_down_i | (apb_key & pwdata_i[`DFP_KEY_DOWN]);
  wire k_store = key_store_i | (apb_key & pwdata_i[`DFP_KEY_STORE]);
  wire k_run = key_run_i | (apb_key & pwdata_i[`DFP_KEY_RUN]);
  wire k_stop = key_stop_i | (apb_key & pwdata_i[`DFP_KEY_STOP]);
  wire dir_rev = ctrl_reg[`DFP_CTRL_DIR_BIT];
  wire lock_high = ctrl_reg[`DFP_CTRL_LOCK_BIT];
  wire [1:0] src_sel = ctrl_reg[`DFP_CTRL_SRC_MSB:`DFP_CTRL_SRC_LSB];
  wire on_freq = show_value_reg & (item_reg[3:0] == `DFP_ITEM_FREQ);
  wire freq_edit = on_freq & (src_sel == `DFP_SRC_KEYPAD);
  wire edit_ok = (state_reg != ST_RUN) |
    (lock_high ? edit_high_ok_i : edit_low_ok_i);
  wire run_ok = (state_reg == ST_STOP);

  assign filt_step_cyc = `DFP_FILT_STEP_CYC;
  assign pready_o = 1'b1;
  assign pslverr_o = 1'b0;
  assign prdata_o = rdata;

  // ========================================================================
  // Run, stop and trip transitions.
  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_STOP: begin
        if (k_run) begin
          state_next = ST_RUN;
        end
      end
      ST_RUN: begin
        if (k_stop) begin
          state_next = ST_STOP;
        end
      end
      ST_TRIP: begin
        if (k_stop) begin
          state_next = ST_STOP;
        end
      end
      default: begin
        state_next = ST_STOP;
      end
    endcase
    if (fault_i) begin
      state_next = ST_TRIP;
    end
  end

  always @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      state_reg <= ST_STOP;
      out_enable_o <= 1'b0;
      run_fwd_o <= 1'b0;
      run_rev_o <= 1'b0;
      decel_stop_o <= 1'b0;
    end else begin
      state_reg <= state_next;
      run_fwd_o <= 1'b0;
      run_rev_o <= 1'b0;
      decel_stop_o <= 1'b0;
      if (state_reg == ST_STOP && state_next == ST_RUN) begin
        run_fwd_o <= ~dir_rev;
        run_rev_o <= dir_rev;
        out_enable_o <= 1'b1;
      end
      if (state_reg == ST_RUN && state_next == ST_STOP) begin
        decel_stop_o <= 1'b1;
      end
      // Output drops once the core reports standstill after the ramp.
      if (state_reg == ST_STOP && state_next != ST_RUN && stopped_i) begin
        out_enable_o <= 1'b0;
      end
      if (state_next == ST_TRIP) begin
        out_enable_o <= 1'b0;
      end
      if (state_reg == ST_TRIP) begin
        out_enable_o <= 1'b0;
      end
    end
  end

  // ========================================================================
  // Navigation, editing and store.
  always @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      program_mode_flag_reg <= 1'b0;
      show_value_reg <= 1'b0;
      item_reg <= 16'h0000;
      edit_val_reg <= 16'h0000;
      edited_reg <= 1'b0;
      target_freq_o <= 16'h0000;
      nvm_write_o <= 1'b0;
      nvm_addr_o <= 16'h0000;
      nvm_data_o <= 16'h0000;
      default_loaded_reg <= 1'b0;
    end else begin
      nvm_write_o <= 1'b0;
      if (!default_loaded_reg) begin
        default_loaded_reg <= 1'b1;
        item_reg <= nvm_default_i;
      end else if (k_func) begin
        show_value_reg <= ~show_value_reg;
        program_mode_flag_reg <= ~show_value_reg &
          (item_reg[15:12] != 4'hD);
        edited_reg <= 1'b0;
        edit_val_reg <= 16'h0000;
      end else if (freq_edit && (k_up || k_down)) begin
        if (k_up && target_freq_o < `DFP_FREQ_MAX) begin
          target_freq_o <= target_freq_o + 16'h0001;
        end else if (k_down && target_freq_o != 16'h0000) begin
          target_freq_o <= target_freq_o - 16'h0001;
        end
      end else if (program_mode_flag_reg && edit_ok) begin
        if (k_up) begin
          edit_val_reg <= edit_val_reg + 16'h0001;
          edited_reg <= 1'b1;
        end else if (k_down) begin
          edit_val_reg <= edit_val_reg - 16'h0001;
          edited_reg <= 1'b1;
        end else if (k_store && edited_reg) begin
          nvm_write_o <= 1'b1;
          nvm_addr_o <= item_reg;
          nvm_data_o <= edit_val_reg;
          edited_reg <= 1'b0;
        end
      end else if (!show_value_reg) begin
        if (k_up) begin
          item_reg <= item_reg + 16'h0001;
        end else if (k_down) begin
          item_reg <= item_reg - 16'h0001;
        end
      end
    end
  end

  // ========================================================================
  // Current filter: first-order step every sixteenth of the time constant.
  // The shift trades settling accuracy for a cheap, multiplier-free update.
  // current low pass
  always @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      filt_curr_reg <= 16'h0000;
      filt_cnt_reg <= 20'h00000;
    end else if (filt_cnt_reg >= filt_step_cyc - 20'h00001) begin
      filt_cnt_reg <= 20'h00000;
      filt_curr_reg <= filt_curr_reg -
        (filt_curr_reg >> `DFP_FILT_SHIFT) +
        (out_curr_i >> `DFP_FILT_SHIFT);
    end else begin
      filt_cnt_reg <= filt_cnt_reg + 20'h00001;
    end
  end

  // ========================================================================
  // Display source selection.
  always @* begin
    disp_val = item_reg;
    raw_seg = 8'h00;
    raw_sel = 1'b0;
    if (show_value_reg) begin
      if (program_mode_flag_reg) begin
        disp_val = edit_val_reg;
      end else begin
        case (item_reg[3:0])
          `DFP_ITEM_FREQ: disp_val = out_freq_i;
          `DFP_ITEM_CURR: disp_val = filt_curr_reg;
          `DFP_ITEM_SCALED: disp_val = scaled_freq_i;
          `DFP_ITEM_IN: begin
            raw_sel = 1'b1;
            raw_seg = in_term_i;
          end
          `DFP_ITEM_OUT: begin
            raw_sel = 1'b1;
            raw_seg = out_term_i;
          end
          default: disp_val = item_reg;
        endcase
      end
    end
  end

  dfp_seg_fmt u_fmt (
    .value_i(disp_val),
    .scaled_i(show_value_reg & ~program_mode_flag_reg &
      (item_reg[3:0] == `DFP_ITEM_SCALED)),
    .raw_seg_i(raw_seg),
    .raw_i(raw_sel),
    .seg_o(fmt_seg)
  );

  // ========================================================================
  // Indicators, registered.
  always @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      run_led_o <= 1'b0;
      program_indicator_o <= 1'b0;
      run_enable_led_o <= 1'b0;
      alarm_led_o <= 1'b0;
      hz_led_o <= 1'b0;
      volt_led_o <= 1'b0;
      amp_led_o <= 1'b0;
      seg_o <= 32'h00000000;
    end else begin
      run_led_o <= out_enable_o;
      program_indicator_o <= program_mode_flag_reg | on_freq;
      run_enable_led_o <= run_ok;
      alarm_led_o <= (state_reg == ST_TRIP);
      seg_o <= fmt_seg;
      hz_led_o <= show_value_reg & (item_reg[3:0] == `DFP_ITEM_FREQ);
      volt_led_o <= show_value_reg & ((item_reg[3:0] == `DFP_ITEM_VOLT) |
        (item_reg[3:0] == `DFP_ITEM_POWER));
      amp_led_o <= show_value_reg & ((item_reg[3:0] == `DFP_ITEM_CURR) |
        (item_reg[3:0] == `DFP_ITEM_POWER));
    end
  end

  // ========================================================================
  // APB registers: zero wait states, unmapped reads return zero.
  always @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl_reg <= `DFP_CTRL_RST;
      key_reg <= 8'h00;
    end else begin
      if (apb_wr && paddr_i == `DFP_CTRL_OFF) begin
        ctrl_reg <= pwdata_i & 32'h00000033;
      end
      if (apb_key) begin
        key_reg <= pwdata_i[7:0] & 8'h3F;
      end
    end
  end

  always @* begin
    rdata = 32'h00000000;
    if (paddr_i == `DFP_CTRL_OFF) begin
      rdata = ctrl_reg;
    end else if (paddr_i == `DFP_STATUS_OFF) begin
      rdata = {26'h0000000, edited_reg, show_value_reg,
        program_mode_flag_reg, out_enable_o, state_reg};
    end else if (paddr_i == `DFP_KEY_OFF) begin
      rdata = {24'h000000, key_reg};
    end else if (paddr_i == `DFP_PARAM_OFF) begin
      rdata = {edit_val_reg, item_reg};
    end else if (paddr_i == `DFP_DISP_OFF) begin
      rdata = seg_o;
    end else if (paddr_i == `DFP_LED_OFF) begin
      rdata = {16'h0000, target_freq_o[7:0], 1'b0, amp_led_o, volt_led_o,
        hz_led_o, alarm_led_o, run_enable_led_o, program_indicator_o,
        run_led_o};
    end
  end
endmodule // dfp_panel

/* File: sim/dfp_panel_monitor.sv */
// Port checker for the drive front panel controller.
`timescale 1ns/1ps
`include "dfp_defs.vh"
module dfp_panel_monitor (
  // Clock, reset and bus
  input wire clk_sys_i,
  input wire rst_i,
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [11:0] paddr_i,
  input wire [31:0] pwdata_i,
  input wire pready_o,
  input wire pslverr_o,
  // Keys and drive core
  input wire key_run_i,
  input wire key_stop_i,
  input wire key_store_i,
  input wire fault_i,
  input wire out_enable_o,
  input wire run_fwd_o,
  input wire run_rev_o,
  input wire decel_stop_o,
  input wire nvm_write_o,
  input wire run_led_o,
  input wire alarm_led_o
);
  // ==========================================================================
  // Key causes
  // A bus write to the key register counts as a press as well.
  wire kw = psel_i & penable_i & pwrite_i & (paddr_i == `DFP_KEY_OFF);
  wire run_c = key_run_i | (kw & pwdata_i[`DFP_KEY_RUN]);
  wire stop_c = key_stop_i | (kw & pwdata_i[`DFP_KEY_STOP]);
  wire store_c = key_store_i | (kw & pwdata_i[`DFP_KEY_STORE]);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  // ==========================================================================
  // Assertions
  a_bus_no_wait: assert property (psel_i && penable_i |->
    pready_o && !pslverr_o)
    else $error("bus access stalled or errored");
  a_trip_out_off: assert property (fault_i |-> ##[1:2] !out_enable_o)
    else $error("output still on after fault");
  a_trip_no_run: assert property (fault_i && run_c |=>
    !run_fwd_o && !run_rev_o)
    else $error("run issued while tripping");
  a_alarm_on: assert property (fault_i |-> ##[1:3] alarm_led_o)
    else $error("alarm lamp not lit on fault");
  a_alarm_clear: assert property ((alarm_led_o && key_stop_i && !fault_i)
    ##1 (!fault_i) [*2] |-> ##[0:1] !alarm_led_o)
    else $error("alarm lamp not cleared by stop");
  a_dir_exclusive: assert property (!(run_fwd_o && run_rev_o))
    else $error("forward and reverse together");
  a_run_cause: assert property ($rose(run_fwd_o || run_rev_o) |->
    $past(run_c, 1) || $past(run_c, 2))
    else $error("run command without run key");
  a_decel_cause: assert property ($rose(decel_stop_o) |->
    $past(stop_c, 1) || $past(stop_c, 2))
    else $error("ramp stop without stop key");
  a_store_cause: assert property ($rose(nvm_write_o) |->
    $past(store_c, 1) || $past(store_c, 2))
    else $error("memory write without store key");
  a_run_led: assert property ($rose(out_enable_o) |-> ##[0:2] run_led_o)
    else $error("run lamp not lit with output");
  c_fwd: cover property (run_fwd_o);
  c_rev: cover property (run_rev_o);
  c_decel: cover property (decel_stop_o);
  c_trip: cover property (alarm_led_o);
endmodule // dfp_panel_monitor

bind dfp_panel dfp_panel_monitor mon (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
  .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
  .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pready_o(pready_o),
  .pslverr_o(pslverr_o), .key_run_i(key_run_i), .key_stop_i(key_stop_i),
  .key_store_i(key_store_i), .fault_i(fault_i), .out_enable_o(out_enable_o),
  .run_fwd_o(run_fwd_o), .run_rev_o(run_rev_o), .decel_stop_o(decel_stop_o),
  .nvm_write_o(nvm_write_o), .run_led_o(run_led_o), .alarm_led_o(alarm_led_o));

/* File: sim/dfp_drive_model.sv */
// Behavioural power stage that answers the panel controller.
`timescale 1ns/1ps
module dfp_drive_model #(
  parameter SPEED = 16'h0010,
  parameter STEP = 4
) (
  // Clock and reset
  input wire clk_sys_i,
  input wire rst_i,
  // Panel commands
  input wire out_enable_i,
  input wire decel_stop_i,
  input wire fault_cmd_i,
  // Feedback to the panel
  output reg stopped_o,
  output reg fault_o,
  output reg [15:0] out_freq_o
);
  reg stopping_reg;
  reg en_d_reg;
  integer div;
  // ==========================================================================
  // Slew and standstill
  // Frequency moves one count per STEP cycles, so a stop takes real time.
  always @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      stopping_reg <= 1'b0;
      en_d_reg <= 1'b0;
      div <= 0;
      stopped_o <= 1'b1;
      fault_o <= 1'b0;
      out_freq_o <= 16'h0000;
    end else begin
      en_d_reg <= out_enable_i;
      fault_o <= fault_cmd_i;
      div <= (div == STEP - 1) ? 0 : div + 1;
      if (decel_stop_i) begin
        stopping_reg <= 1'b1;
      end else if (out_enable_i && !en_d_reg) begin
        stopping_reg <= 1'b0;
      end
      if (div == 0 && out_enable_i && !stopping_reg &&
          out_freq_o < SPEED) begin
        out_freq_o <= out_freq_o + 16'h0001;
      end else if (div == 0 && (stopping_reg || !out_enable_i) &&
                   out_freq_o != 16'h0000) begin
        out_freq_o <= out_freq_o - 16'h0001;
      end
      // A fresh start never reports standstill on its first edge.
      stopped_o <= (out_freq_o == 16'h0000) &&
                   ((stopping_reg && en_d_reg) || !out_enable_i);
    end
  end
endmodule // dfp_drive_model

/* File: sim/tb.sv */
// Self-checking bench for the drive front panel controller.
`timescale 1ns/1ps
`include "dfp_defs.vh"
module tb;
  // ==========================================================================
  // Stimulus and observed signals
  logic clk_sys_i = 0;
  logic rst_i = 1;
  logic psel = 0, penable = 0, pwrite = 0, fault_cmd = 0, lo_ok = 1;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000, prdata, q;
  logic [5:0] keys = 6'h00;
  logic [15:0] nvm_def = 16'hD001, ofreq, tgt, nva, nvd, sfreq = 16'h0000;
  logic [7:0] in_term = 8'h00;
  logic [6:0] leds; // Run, prog, run-enable, alarm, hz, volt, amp.
  logic pready, pslverr, fault, stopped, out_en, fwd, rev, dec, nvw;
  logic [31:0] seg;
  int fails = 0, total_checks = 0, cyc = 0, n_fwd = 0, n_rev = 0, n_dec = 0;
  int a, b, d, n_wr = 0;
  logic [15:0] items [4] = '{`DFP_ITEM_FREQ, `DFP_ITEM_CURR,
                             `DFP_ITEM_VOLT, `DFP_ITEM_POWER};
  logic [2:0] units [4] = '{3'h1, 3'h4, 3'h2, 3'h6};

  dfp_panel dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .key_func_i(keys[0]), .key_up_i(keys[1]),
    .key_down_i(keys[2]), .key_store_i(keys[3]), .key_run_i(keys[4]),
    .key_stop_i(keys[5]), .fault_i(fault), .stopped_i(stopped),
    .out_freq_i(ofreq), .out_curr_i(ofreq), .scaled_freq_i(sfreq),
    .in_term_i(in_term), .out_term_i(~in_term), .nvm_default_i(nvm_def),
    .edit_low_ok_i(lo_ok), .edit_high_ok_i(~lo_ok), .out_enable_o(out_en),
    .run_fwd_o(fwd), .run_rev_o(rev), .decel_stop_o(dec),
    .target_freq_o(tgt), .nvm_write_o(nvw), .nvm_addr_o(nva),
    .nvm_data_o(nvd),
    .run_led_o(leds[0]), .program_indicator_o(leds[1]),
    .run_enable_led_o(leds[2]), .alarm_led_o(leds[3]), .hz_led_o(leds[4]),
    .volt_led_o(leds[5]), .amp_led_o(leds[6]), .seg_o(seg));
  dfp_drive_model drive (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
    .out_enable_i(out_en), .decel_stop_i(dec), .fault_cmd_i(fault_cmd),
    .stopped_o(stopped), .fault_o(fault), .out_freq_o(ofreq));

  // ==========================================================================
  // Clock, pulse counters and hang guard
  initial forever #20 clk_sys_i = ~clk_sys_i;
  // The ceiling is roughly fifty times the longest expected run.
  always @(posedge clk_sys_i) begin
    cyc++;
    n_fwd += (fwd === 1'b1);
    n_rev += (rev === 1'b1);
    n_dec += (dec === 1'b1);
    n_wr += (nvw === 1'b1);
    if (cyc == 20000) begin
      fails++;
      give_verdict();
    end
  end

  // ==========================================================================
  // Shared tasks
  task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task give_verdict;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task tick(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask
  // One bus transfer; the access phase lasts until pready is seen high.
  // Only the hang guard ends a wait; an idle edge separates transfers.
  task apb(input logic w, input logic [11:0] ad, input logic [31:0] wd);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= wd;
    tick(1);
    penable <= 1'b1;
    do begin
      tick(1);
    end while (pready !== 1'b1);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    tick(1);
  endtask
  task press(input int k);
    keys <= 6'h01 << k;
    tick(1);
    keys <= 6'h00;
    tick(3);
  endtask
  task do_reset(input logic [15:0] item);
    rst_i <= 1'b1;
    nvm_def <= item;
    tick(20);
    rst_i <= 1'b0;
    tick(3);
  endtask

  // ==========================================================================
  // Scenarios
  task t_regs;
    apb(1'b0, `DFP_CTRL_OFF, 32'h0);
    chk("ctrl reset", q, `DFP_CTRL_RST);
    apb(1'b1, 12'h020, 32'hFFFFFFFF);
    apb(1'b0, 12'h020, 32'h0);
    chk("unmapped read", q, 32'h0);
    apb(1'b0, `DFP_STATUS_OFF, 32'h0);
    chk("state stop", q[1:0], 2'h0);
    chk("run enable lamp", leds[2], 1'b1);
  endtask
  task run_once(input logic dir);
    apb(1'b1, `DFP_CTRL_OFF, {31'h0, dir});
    a = n_fwd;
    b = n_rev;
    d = n_dec;
    press(`DFP_KEY_RUN);
    chk("fwd pulses", n_fwd - a, !dir);
    chk("rev pulses", n_rev - b, dir);
    apb(1'b0, `DFP_STATUS_OFF, 32'h0);
    chk("state run", q[1:0], 2'h1);
    chk("run lamp on", leds[0], 1'b1);
    chk("run enable dark", leds[2], 1'b0);
    press(`DFP_KEY_STOP);
    chk("decel pulses", n_dec - d, 1);
    a = 0;
    while (out_en !== 1'b0 && a < 2000) begin
      tick(1);
      a++;
    end
    tick(3);
    chk("run lamp off", leds[0], 1'b0);
  endtask
  task t_trip;
    press(`DFP_KEY_RUN);
    tick(20);
    fault_cmd <= 1'b1;
    tick(4);
    chk("trip output", out_en, 1'b0);
    chk("alarm lamp on", leds[3], 1'b1);
    fault_cmd <= 1'b0;
    a = n_fwd + n_rev;
    press(`DFP_KEY_RUN);
    apb(1'b0, `DFP_STATUS_OFF, 32'h0);
    chk("state trip", q[1:0], 2'h2);
    press(`DFP_KEY_STOP);
    chk("alarm lamp off", leds[3], 1'b0);
    apb(1'b0, `DFP_STATUS_OFF, 32'h0);
    chk("state after clear", q[2:0], 3'h0);
    chk("no restart", n_fwd + n_rev - a, 0);
  endtask
  task t_items;
    for (int i = 0; i < 4; i++) begin
      do_reset(16'hD000 | items[i]);
      apb(1'b0, `DFP_PARAM_OFF, 32'h0);
      chk("default item", q[15:0], 16'hD000 | items[i]);
      press(`DFP_KEY_FUNC);
      chk("unit lamps", {leds[6], leds[5], leds[4]}, units[i]);
      if (i == 0) begin
        chk("prog lamp", leds[1], 1'b1);
        apb(1'b1, `DFP_CTRL_OFF, 32'h00000020);
        press(`DFP_KEY_UP);
        chk("target raised", tgt, 16'h0001);
      end
    end
    do_reset(16'hD000 | `DFP_ITEM_IN);
    press(`DFP_KEY_FUNC);
    chk("terminals off", seg, 32'h00000000);
    in_term <= 8'hFF;
    tick(3);
    chk("terminal segments", seg, 32'h000000FF);
    // 123.45 in hundredths reads 123.4, the point on digit one.
    do_reset(16'hD000 | `DFP_ITEM_SCALED);
    sfreq <= 16'h3039;
    press(`DFP_KEY_FUNC);
    chk("scaled digits", seg, 32'h065BCF66);
  endtask
  // Run-mode edits obey the access level; store commits the value.
  task t_edit;
    do_reset(16'h0012);
    press(`DFP_KEY_FUNC);
    press(`DFP_KEY_UP);
    press(`DFP_KEY_UP);
    press(`DFP_KEY_RUN);
    lo_ok <= 1'b0;
    press(`DFP_KEY_UP);
    apb(1'b0, `DFP_PARAM_OFF, 32'h0);
    chk("locked edit", q, 32'h00020012);
    chk("run and prog lamps", leds[1:0], 2'h3);
    apb(1'b1, `DFP_CTRL_OFF, 32'h00000002);
    press(`DFP_KEY_UP);
    a = n_wr;
    press(`DFP_KEY_STORE);
    chk("store pulses", n_wr - a, 1);
    chk("store target", {nva, nvd}, 32'h00120003);
  endtask

  // ==========================================================================
  // Main sequence
  initial begin
    tick(20);
    rst_i <= 1'b0;
    tick(3);
    t_regs();
    run_once(1'b0);
    run_once(1'b1);
    t_trip();
    t_items();
    t_edit();
    give_verdict();
  end
endmodule // tb
